// file: rtl/fps_pkg.sv
// Shared constants, types and timing for the flash programmer-mode sequencer.
package fps_pkg;

	// ****************************************************************
	// Clock and timing
	// ****************************************************************
	localparam int unsigned CLK_KHZ      = 10000;  // 10 MHz system clock.
	localparam int unsigned T_OSC_MS     = 10;     // Oscillator settling, crystal case.
	localparam int unsigned T_SETUP_MS   = 10;     // Programmer-mode setup time.
	localparam int unsigned SETUP_CYCLES = (T_OSC_MS + T_SETUP_MS) * CLK_KHZ;
	localparam int unsigned SETUP_CNT_W  = 18;     // Wide enough for SETUP_CYCLES.

	// ****************************************************************
	// Command codes
	// ****************************************************************
	localparam logic [7:0] CMD_READ   = 8'h00;
	localparam logic [7:0] CMD_PROG   = 8'h40;
	localparam logic [7:0] CMD_ERASE  = 8'h20;
	localparam logic [7:0] CMD_STATUS = 8'h71;

	// ****************************************************************
	// Return code layout and polling encoding
	// ****************************************************************
	localparam int unsigned RC_ABNORMAL  = 7;
	localparam int unsigned RC_CMD_ERR   = 6;
	localparam int unsigned RC_PROG_ERR  = 5;
	localparam int unsigned RC_ERASE_ERR = 4;
	localparam int unsigned RC_EXCESS    = 1;
	localparam int unsigned RC_ADDR_ERR  = 0;
	localparam logic [7:0]  RC_RESET     = 8'h00;
	localparam logic [7:0]  RC_CMD_FAIL  = 8'hC0;
	localparam logic [1:0]  POLL_BUSY    = 2'h0;
	localparam logic [1:0]  POLL_FAIL    = 2'h2;
	localparam logic [1:0]  POLL_OK      = 2'h3;
	localparam logic [5:0]  POLL_FILL    = 6'h00;
	localparam logic [7:0]  DQ_IDLE      = 8'h00;

	// ****************************************************************
	// Carriers
	// ****************************************************************
	typedef struct packed {
		logic       ce_n;
		logic       oe_n;
		logic       we_n;
		logic [7:0] data;
	} fps_pins_s;

	localparam int unsigned PINS_W    = 11;
	localparam logic [10:0] PINS_IDLE = 11'h700;  // Strobes high, data low.

	typedef struct packed {
		logic done;       // One-cycle pulse: erase finished.
		logic erase_err;
		logic excess;
		logic addr_err;
	} fps_arr_stat_s;

	// ****************************************************************
	// States and modes
	// ****************************************************************
	typedef enum logic [2:0] {
		ST_SETUP   = 3'h0,
		ST_READ    = 3'h1,
		ST_ERASE2  = 3'h2,
		ST_STATUS2 = 3'h3,
		ST_ERASING = 3'h4,
		ST_POLL    = 3'h5,
		ST_STATUS  = 3'h6
	} fps_state_e;

	typedef enum logic [2:0] {
		LSI_ACTIVE    = 3'h0,
		LSI_SUBACTIVE = 3'h1,
		LSI_SLEEP     = 3'h2,
		LSI_SUBSLEEP  = 3'h3,
		LSI_STANDBY   = 3'h4,
		LSI_WATCH     = 3'h5
	} fps_lsi_mode_e;

	typedef enum logic [1:0] {
		FPWR_NORMAL = 2'h0,
		FPWR_PDOWN  = 2'h1,
		FPWR_HALT   = 2'h2
	} fps_flash_pwr_e;

endpackage : fps_pkg

// file: rtl/fps_power.sv
// Maps the chip operating mode onto the flash power state.
`timescale 1ns/10ps
module fps_power (
	input  wire logic                   i_clk,
	input  wire logic                   i_rst_n,
	input  wire fps_pkg::fps_lsi_mode_e i_lsi_mode,
	input  wire logic                   i_subactive_flash_full_power,
	output fps_pkg::fps_flash_pwr_e     o_flash_pwr,
	output logic                        o_flash_read_ok
);
	import fps_pkg::*;

	fps_flash_pwr_e pwr_nxt;

	// ****************************************************************
	// Mode decode
	// ****************************************************************
	// Unknown mode codes halt the flash, the safe choice for power.
	always_comb begin
		case (i_lsi_mode)
			LSI_ACTIVE:    pwr_nxt = FPWR_NORMAL;
			LSI_SLEEP:     pwr_nxt = FPWR_NORMAL;
			LSI_SUBACTIVE: pwr_nxt = i_subactive_flash_full_power ? FPWR_NORMAL : FPWR_PDOWN;
			LSI_SUBSLEEP:  pwr_nxt = FPWR_HALT;
			LSI_STANDBY:   pwr_nxt = FPWR_HALT;
			LSI_WATCH:     pwr_nxt = FPWR_HALT;
			default:       pwr_nxt = FPWR_HALT;
		endcase
	end

	// Registered state; power-down still allows slow reads.
	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			o_flash_pwr     <= FPWR_NORMAL;
			o_flash_read_ok <= 1'b1;
		end else begin
			o_flash_pwr     <= pwr_nxt;
			o_flash_read_ok <= (pwr_nxt != FPWR_HALT);
		end
	end

	// ****************************************************************
	// Checks
	// ****************************************************************
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_rst_n);

	chk_subact_pdown: assert property ((i_lsi_mode == LSI_SUBACTIVE && !i_subactive_flash_full_power)
		|=> (o_flash_pwr == FPWR_PDOWN && o_flash_read_ok)) else $error("subactive did not power down");
	chk_halt_modes: assert property ((i_lsi_mode inside {LSI_SUBSLEEP, LSI_STANDBY, LSI_WATCH})
		|=> (o_flash_pwr == FPWR_HALT && !o_flash_read_ok)) else $error("flash not halted");

endmodule : fps_power

// file: rtl/fps_seq.sv
// Programmer-mode command sequencer: erase, status polling and status read.
`timescale 1ns/10ps
module fps_seq #(
	parameter int unsigned P_SETUP_CYCLES = fps_pkg::SETUP_CYCLES
) (
	input  wire logic                   i_clk,
	input  wire logic                   i_rst_n,
	input  wire logic                   i_ce_n,
	input  wire logic                   i_oe_n,
	input  wire logic                   i_we_n,
	input  wire logic [7:0]             i_dq,
	input  wire logic [7:0]             i_arr_rdata,
	input  wire fps_pkg::fps_arr_stat_s i_arr_stat,
	input  wire fps_pkg::fps_lsi_mode_e i_lsi_mode,
	input  wire logic                   i_subactive_flash_full_power,
	output logic [7:0]                  o_dq,
	output logic                        o_dq_oe,
	output logic                        o_erase_start,
	output logic                        o_setup_done,
	output fps_pkg::fps_flash_pwr_e     o_flash_pwr,
	output logic                        o_flash_read_ok
);
	import fps_pkg::*;

	// ****************************************************************
	// Pin synchronisation
	// ****************************************************************
	fps_pins_s                pins;
	logic                     we_n_q_r;
	logic                     wr_evt;
	logic                     read_en;
	logic [7:0]               wr_data;

	fps_sync #(
		.W       (PINS_W),
		.RST_VAL (PINS_IDLE)
	) u_sync (
		.i_clk   (i_clk),
		.i_rst_n (i_rst_n),
		.i_async ({i_ce_n, i_oe_n, i_we_n, i_dq}),
		.o_sync  (pins)
	);

	// Delayed write strobe for rising-edge detection on synchronised pins.
	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			we_n_q_r <= 1'b1;
		end else begin
			we_n_q_r <= pins.we_n;
		end
	end

	// A command write is taken at the end of the write pulse, with chip enable low.
	assign wr_evt  = !pins.ce_n && pins.we_n && !we_n_q_r;
	assign wr_data = pins.data;
	assign read_en = !pins.ce_n && !pins.oe_n && pins.we_n;

	// ****************************************************************
	// Setup period
	// ****************************************************************
	logic [SETUP_CNT_W-1:0]   setup_cnt_r;
	logic                     setup_end;

	assign setup_end = (setup_cnt_r == SETUP_CNT_W'(P_SETUP_CYCLES - 1));

	// Counts oscillator settling plus programmer setup once after reset.
	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			setup_cnt_r  <= '0;
			o_setup_done <= 1'b0;
		end else if (!o_setup_done) begin
			setup_cnt_r  <= setup_cnt_r + SETUP_CNT_W'(1);
			o_setup_done <= setup_end;
		end
	end

	// ****************************************************************
	// Command state machine
	// ****************************************************************
	fps_state_e               state_r;
	fps_state_e               state_nxt;
	logic [1:0]               poll_r;
	logic [1:0]               poll_nxt;
	logic [7:0]               rc_r;
	logic [7:0]               rc_nxt;
	logic                     erase_start_nxt;
	logic                     erase_fail;

	assign erase_fail = i_arr_stat.erase_err || i_arr_stat.excess || i_arr_stat.addr_err;

	// Next state, polling flags and return code; error sets come after clears so they win.
	always_comb begin
		state_nxt       = state_r;
		poll_nxt        = poll_r;
		rc_nxt          = rc_r;
		erase_start_nxt = 1'b0;
		case (state_r)
			ST_SETUP: begin
				if (setup_end) begin
					state_nxt = ST_READ;
				end
			end
			ST_READ, ST_POLL, ST_STATUS: begin
				if (wr_evt) begin
					if (wr_data != CMD_STATUS) begin
						rc_nxt = RC_RESET;
					end
					if (wr_data == CMD_READ) begin
						state_nxt = ST_READ;
					end else if (wr_data == CMD_ERASE) begin
						state_nxt = ST_ERASE2;
					end else if (wr_data == CMD_STATUS) begin
						state_nxt = ST_STATUS2;
					end else begin
						state_nxt = ST_POLL;
						poll_nxt  = POLL_FAIL;
						rc_nxt    = RC_CMD_FAIL;
					end
				end
			end
			ST_ERASE2: begin
				if (wr_evt) begin
					if (wr_data == CMD_ERASE) begin
						state_nxt       = ST_ERASING;
						poll_nxt        = POLL_BUSY;
						erase_start_nxt = 1'b1;
					end else begin
						state_nxt = ST_POLL;
						poll_nxt  = POLL_FAIL;
						rc_nxt    = RC_CMD_FAIL;
					end
				end
			end
			ST_STATUS2: begin
				if (wr_evt) begin
					if (wr_data == CMD_STATUS) begin
						state_nxt = ST_STATUS;
					end else begin
						state_nxt = ST_POLL;
						poll_nxt  = POLL_FAIL;
						rc_nxt    = RC_CMD_FAIL;
					end
				end
			end
			ST_ERASING: begin
				// Writes during erase are dropped; the programmer must not send any.
				if (i_arr_stat.done) begin
					state_nxt            = ST_POLL;
					poll_nxt             = erase_fail ? POLL_FAIL : POLL_OK;
					rc_nxt               = RC_RESET;
					rc_nxt[RC_ABNORMAL]  = erase_fail;
					rc_nxt[RC_ERASE_ERR] = i_arr_stat.erase_err;
					rc_nxt[RC_EXCESS]    = i_arr_stat.excess;
					rc_nxt[RC_ADDR_ERR]  = i_arr_stat.addr_err;
				end
			end
			default: begin
				state_nxt = ST_SETUP;
			end
		endcase
	end

	// State register.
	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			state_r <= ST_SETUP;
		end else begin
			state_r <= state_nxt;
		end
	end

	// Polling flags and return code, held until the next command write or the end of an erase.
	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			poll_r <= POLL_BUSY;
			rc_r   <= RC_RESET;
		end else begin
			poll_r <= poll_nxt;
			rc_r   <= rc_nxt;
		end
	end

	// Erase start pulse to the array; it always covers the whole array.
	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			o_erase_start <= 1'b0;
		end else begin
			o_erase_start <= erase_start_nxt;
		end
	end

	// ****************************************************************
	// Data pin drive
	// ****************************************************************
	logic [7:0]               dq_nxt;

	// Output word per mode; polling leaves bits 5 to 0 at zero.
	always_comb begin
		case (state_r)
			ST_READ:    dq_nxt = i_arr_rdata;
			ST_ERASING: dq_nxt = {POLL_BUSY, POLL_FILL};
			ST_POLL:    dq_nxt = {poll_r, POLL_FILL};
			ST_STATUS:  dq_nxt = rc_r;
			default:    dq_nxt = DQ_IDLE;
		endcase
	end

	// Drive only while chip and output enable are low and setup has ended.
	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			o_dq    <= DQ_IDLE;
			o_dq_oe <= 1'b0;
		end else begin
			o_dq    <= dq_nxt;
			o_dq_oe <= read_en && (state_r != ST_SETUP);
		end
	end

	// ****************************************************************
	// Flash power state
	// ****************************************************************
	fps_power u_power (
		.i_clk                        (i_clk),
		.i_rst_n                      (i_rst_n),
		.i_lsi_mode                   (i_lsi_mode),
		.i_subactive_flash_full_power (i_subactive_flash_full_power),
		.o_flash_pwr                  (o_flash_pwr),
		.o_flash_read_ok              (o_flash_read_ok)
	);

	// ****************************************************************
	// Checks
	// ****************************************************************
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_rst_n);

	chk_erase_two_writes: assert property ($rose(o_erase_start) |-> $past(state_r) == ST_ERASE2
		&& state_r == ST_ERASING) else $error("erase started without two writes");
	chk_setup_reject: assert property ((state_r == ST_SETUP && !setup_end) |=> state_r == ST_SETUP
		&& !o_erase_start) else $error("command taken during setup");
	chk_setup_to_read: assert property ((state_r == ST_SETUP && setup_end) |=> state_r == ST_READ)
		else $error("setup did not enter read mode");
	chk_busy_output: assert property ((state_r == ST_ERASING && read_en) |=> o_dq_oe
		&& o_dq == DQ_IDLE) else $error("busy poll value wrong");
	chk_poll_hold: assert property ((state_r == ST_POLL && !wr_evt) |=> $stable(poll_r)
		&& state_r == ST_POLL) else $error("poll flags lost");
	chk_poll_format: assert property ((state_r == ST_POLL && read_en) |=> o_dq[7] && o_dq[5:0] == POLL_FILL)
		else $error("poll end format wrong");
	chk_rc_keep: assert property ((wr_evt && wr_data == CMD_STATUS && state_r inside {ST_READ, ST_POLL,
		ST_STATUS, ST_STATUS2}) |=> $stable(rc_r)) else $error("status command altered code");
	chk_rc_unused: assert property (rc_r[3:2] == 2'h0 && (!rc_r[RC_CMD_ERR] || rc_r[RC_ABNORMAL]))
		else $error("return code bits invalid");
	chk_done_return: assert property ((state_r == ST_ERASING && i_arr_stat.done) |=> state_r == ST_POLL
		##1 ($past(wr_evt) || state_r == ST_POLL)) else $error("no command wait after erase");
	chk_status_out: assert property ((state_r == ST_STATUS && read_en) |=> o_dq == $past(rc_r))
		else $error("status read output wrong");

	// A request pulse that stretched would start a second whole-array erase behind the first.
	chk_erase_pulse: assert property (o_erase_start |=> !o_erase_start)
		else $error("erase request longer than one cycle");
	chk_erase_ignore: assert property ((state_r == ST_ERASING && !i_arr_stat.done) |=> state_r == ST_ERASING
		&& !o_erase_start) else $error("erase left without array end");
	chk_cmd_err_code: assert property ((state_r == ST_ERASE2 && wr_evt && wr_data != CMD_ERASE)
		|=> rc_r == RC_CMD_FAIL && poll_r == POLL_FAIL) else $error("command error not flagged");
	chk_rc_clear: assert property ((wr_evt && wr_data == CMD_READ && state_r inside {ST_READ, ST_POLL,
		ST_STATUS}) |=> rc_r == RC_RESET && state_r == ST_READ) else $error("return code not cleared");
	chk_read_data: assert property ((state_r == ST_READ && read_en) |=> o_dq_oe && o_dq == $past(i_arr_rdata))
		else $error("memory read data wrong");
	chk_no_drive_setup: assert property ((state_r == ST_SETUP) |=> !o_dq_oe)
		else $error("data bus driven during setup");
	chk_erase_ok_code: assert property ((state_r == ST_ERASING && i_arr_stat.done && !erase_fail)
		|=> poll_r == POLL_OK && rc_r == RC_RESET) else $error("normal erase end code wrong");

	// Scenario covers: both erase endings, a status read, a command error and flash power-down.
	cov_erase_ok: cover property (state_r == ST_ERASING && i_arr_stat.done && !erase_fail);
	cov_erase_fail: cover property (state_r == ST_ERASING && i_arr_stat.done && erase_fail);
	cov_status_read: cover property (state_r == ST_STATUS && read_en);
	cov_cmd_error: cover property (state_r == ST_ERASE2 && wr_evt && wr_data != CMD_ERASE);
	cov_power_down: cover property (o_flash_pwr == FPWR_PDOWN && o_flash_read_ok);

endmodule : fps_seq

// file: rtl/fps_sync.sv
// Two-flop synchroniser for the programmer pins, one chain per bit.
`timescale 1ns/10ps
module fps_sync #(
	parameter int unsigned       W       = 11,
	parameter logic [W-1:0]      RST_VAL = '0
) (
	input  wire logic            i_clk,
	input  wire logic            i_rst_n,
	input  wire logic [W-1:0]    i_async,
	output logic      [W-1:0]    o_sync
);
	import fps_pkg::*;

	// ****************************************************************
	// Per-bit chains
	// ****************************************************************
	// The first stage feeds only the second, so metastability stays inside the chain.
	genvar g;
	generate
		for (g = 0; g < W; g++) begin : g_bit
			logic meta_r;
			always_ff @(posedge i_clk) begin
				if (!i_rst_n) begin
					meta_r    <= RST_VAL[g];
					o_sync[g] <= RST_VAL[g];
				end else begin
					meta_r    <= i_async[g];
					o_sync[g] <= meta_r;
				end
			end
		end
	endgenerate

endmodule : fps_sync

// file: verif/fps_prog_model.sv
// Behavioural model of the external parallel programmer that drives the flash pins.
`timescale 1ns/10ps
module fps_prog_model (
	input  wire logic       i_clk,
	input  wire logic [7:0] i_bus,
	input  wire logic       i_dev_drv,
	output logic            o_ce_n,
	output logic            o_oe_n,
	output logic            o_we_n,
	output logic [7:0]      o_dq
);
	import fps_pkg::*;

	localparam int unsigned T_STATUS_CYC = 200;  // 20 us at 10 MHz.

	// Strobes idle high; the data bus idles at a non-zero pattern.
	initial begin
		o_ce_n = 1'b1;
		o_oe_n = 1'b1;
		o_we_n = 1'b1;
		o_dq   = 8'hA5;
	end

	// ****************************************************************
	// Pin cycles
	// ****************************************************************
	// Pins move on the falling edge and stay four cycles, so the two-flop synchroniser always sees them.
	task automatic write_cmd(input logic [7:0] code);
		@(negedge i_clk);
		o_ce_n = 1'b0;
		o_dq   = code;
		o_we_n = 1'b0;
		repeat (4) @(negedge i_clk);
		o_we_n = 1'b1;
		repeat (4) @(negedge i_clk);
		o_ce_n = 1'b1;
		o_dq   = ~code;  // Released bus shows the inverse, so stale data cannot pass for a match.
	endtask : write_cmd

	// A read holds both enables until the registered output has settled, then backs off.
	task automatic read_bus(output logic [7:0] data, output logic drv);
		@(negedge i_clk);
		o_ce_n = 1'b0;
		o_oe_n = 1'b0;
		repeat (5) @(negedge i_clk);
		data = i_bus;
		drv  = i_dev_drv;
		o_ce_n = 1'b1;
		o_oe_n = 1'b1;
		repeat (4) @(negedge i_clk);
	endtask : read_bus

	// Two-cycle commands always carry the same code twice.
	task automatic erase_cmd();
		write_cmd(CMD_ERASE);
		write_cmd(CMD_ERASE);
	endtask : erase_cmd

	// The return code is not read before the settling time after the command.
	task automatic status_cmd();
		write_cmd(CMD_STATUS);
		write_cmd(CMD_STATUS);
		repeat (T_STATUS_CYC) @(negedge i_clk);
	endtask : status_cmd

endmodule : fps_prog_model

// file: verif/fps_seq_test.sv
// Self-checking testbench for the programmer-mode sequencer.
`timescale 1ns/10ps
module fps_seq_test;
	import fps_pkg::*;

	localparam int unsigned SETUP_N    = 20;
	localparam int unsigned T_POLL_CYC = 10000;  // 1 ms at 10 MHz.
	localparam int unsigned T_WAKE_CYC = 200;    // 20 us at 10 MHz.

	typedef struct packed {
		fps_lsi_mode_e  mode;
		logic           full;
		fps_flash_pwr_e pwr;
		logic           rd_ok;
	} fps_pwr_row_s;

	logic           clk;
	logic           rst_n;
	logic           ce_n;
	logic           oe_n;
	logic           we_n;
	logic           dq_oe;
	logic           erase_start;
	logic           setup_done;
	logic           read_ok;
	logic           full_pwr;
	logic           seen_oe;
	logic [7:0]     prog_dq;
	logic [7:0]     dut_dq;
	logic [7:0]     bus;
	logic [7:0]     arr_rdata;
	logic [7:0]     seen;
	fps_arr_stat_s  arr_stat;
	fps_lsi_mode_e  lsi_mode;
	fps_flash_pwr_e flash_pwr;
	int             n_mismatch;
	int             samples_checked;
	int             n_start;
	int             cnt;
	fps_pwr_row_s   rows [12];
	logic [7:0]     bad [3][2];

	// The shared data wire carries whichever side has its output enabled.
	assign bus = (dq_oe === 1'b1) ? dut_dq : prog_dq;

	fps_seq #(.P_SETUP_CYCLES(SETUP_N)) dut (
		.i_clk                        (clk),
		.i_rst_n                      (rst_n),
		.i_ce_n                       (ce_n),
		.i_oe_n                       (oe_n),
		.i_we_n                       (we_n),
		.i_dq                         (bus),
		.i_arr_rdata                  (arr_rdata),
		.i_arr_stat                   (arr_stat),
		.i_lsi_mode                   (lsi_mode),
		.i_subactive_flash_full_power (full_pwr),
		.o_dq                         (dut_dq),
		.o_dq_oe                      (dq_oe),
		.o_erase_start                (erase_start),
		.o_setup_done                 (setup_done),
		.o_flash_pwr                  (flash_pwr),
		.o_flash_read_ok              (read_ok)
	);

	fps_prog_model prog (
		.i_clk     (clk),
		.i_bus     (bus),
		.i_dev_drv (dq_oe),
		.o_ce_n    (ce_n),
		.o_oe_n    (oe_n),
		.o_we_n    (we_n),
		.o_dq      (prog_dq)
	);

	// Clock and a count of cycles in which the whole-array erase request is high.
	initial clk = 1'b0;
	always #50 clk = ~clk;
	always @(posedge clk) begin
		if (erase_start === 1'b1) begin
			n_start++;
		end
	end

	// ****************************************************************
	// Checking helpers
	// ****************************************************************
	task automatic check(input string name, input logic [7:0] got, input logic [7:0] exp);
		samples_checked++;
		if (got !== exp) begin
			n_mismatch++;
			$display("unexpected %s: expected %h seen %h", name, exp, got);
		end
	endtask : check

	task automatic rd_chk(input string name, input logic [7:0] exp);
		prog.read_bus(seen, seen_oe);
		check(name, seen, exp);
		check("dq_oe", {7'h00, seen_oe}, 8'h01);
	endtask : rd_chk

	// One erase: a single request, busy while running, end code held over two reads.
	task automatic erase_run(input logic e, input logic x, input logic a, input logic [7:0] exp);
		cnt = n_start;
		prog.erase_cmd();
		repeat (T_POLL_CYC) @(negedge clk);
		check("erase_req", 8'(n_start - cnt), 8'h01);
		rd_chk("poll_busy", 8'h00);
		arr_stat = '{1'b1, e, x, a};
		@(negedge clk);
		arr_stat = '0;
		rd_chk("poll_end", exp);
		rd_chk("poll_held", exp);
	endtask : erase_run

	task automatic final_report();
		$display("checks %0d mismatches %0d", samples_checked, n_mismatch);
		if (n_mismatch == 0 && samples_checked > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask : final_report

	// A hang is cut off well past the expected run of about 24500 cycles.
	initial begin
		#(40000 * 100);
		n_mismatch++;
		final_report();
	end

	// ****************************************************************
	// Main sequence
	// ****************************************************************
	initial begin
		rows = '{'{LSI_ACTIVE, 1'b0, FPWR_NORMAL, 1'b1}, '{LSI_ACTIVE, 1'b1, FPWR_NORMAL, 1'b1},
			'{LSI_SUBACTIVE, 1'b0, FPWR_PDOWN, 1'b1}, '{LSI_SUBACTIVE, 1'b1, FPWR_NORMAL, 1'b1},
			'{LSI_SLEEP, 1'b0, FPWR_NORMAL, 1'b1}, '{LSI_SLEEP, 1'b1, FPWR_NORMAL, 1'b1},
			'{LSI_SUBSLEEP, 1'b0, FPWR_HALT, 1'b0}, '{LSI_SUBSLEEP, 1'b1, FPWR_HALT, 1'b0},
			'{LSI_STANDBY, 1'b0, FPWR_HALT, 1'b0}, '{LSI_STANDBY, 1'b1, FPWR_HALT, 1'b0},
			'{LSI_WATCH, 1'b0, FPWR_HALT, 1'b0}, '{LSI_WATCH, 1'b1, FPWR_HALT, 1'b0}};
		bad = '{'{CMD_PROG, CMD_PROG}, '{CMD_ERASE, CMD_STATUS}, '{CMD_STATUS, CMD_ERASE}};
		n_mismatch = 0;
		samples_checked = 0;
		n_start = 0;
		rst_n = 1'b0;
		arr_rdata = 8'h5A;
		arr_stat = '0;
		lsi_mode = LSI_ACTIVE;
		full_pwr = 1'b0;
		repeat (8) @(negedge clk);
		check("setup_rst", {7'h00, setup_done}, 8'h00);
		check("oe_rst", {7'h00, dq_oe}, 8'h00);
		check("pwr_rst", 8'(flash_pwr), 8'(FPWR_NORMAL));
		rst_n = 1'b1;
		// A write landing inside setup must be dropped; setup lasts exactly the set count.
		fork
			begin
				cnt = 0;
				do begin
					@(posedge clk);
					#1;
					cnt++;
				end while (setup_done !== 1'b1 && cnt < 100);
			end
			prog.write_cmd(CMD_ERASE);
		join
		check("setup_len", 8'(cnt), 8'(SETUP_N));
		prog.write_cmd(CMD_READ);
		rd_chk("mem_read", 8'h5A);
		$display("test reset and setup done");
		erase_run(1'b0, 1'b0, 1'b0, 8'hC0);
		prog.status_cmd();
		rd_chk("rc_ok", 8'h00);
		$display("test erase normal done");
		erase_run(1'b1, 1'b1, 1'b1, 8'h80);
		prog.status_cmd();
		rd_chk("rc_fail", 8'h93);
		prog.status_cmd();
		rd_chk("rc_kept", 8'h93);
		arr_rdata = 8'h3C;
		prog.write_cmd(CMD_READ);
		rd_chk("mem_after", 8'h3C);
		prog.status_cmd();
		rd_chk("rc_clear", 8'h00);
		$display("test erase failure done");
		foreach (bad[i]) begin
			prog.write_cmd(bad[i][0]);
			prog.write_cmd(bad[i][1]);
			rd_chk("cmd_err_poll", 8'h80);
			prog.status_cmd();
			rd_chk("cmd_err_rc", 8'hC0);
		end
		$display("test command errors done");
		// A reset in mid-run restarts setup and clears the return code left by the command errors.
		rst_n = 1'b0;
		repeat (3) @(negedge clk);
		check("setup_rst2", {7'h00, setup_done}, 8'h00);
		rst_n = 1'b1;
		repeat (SETUP_N + 4) @(negedge clk);
		check("setup_end2", {7'h00, setup_done}, 8'h01);
		prog.status_cmd();
		rd_chk("rc_after_rst", 8'h00);
		$display("test mid-run reset done");
		foreach (rows[i]) begin
			lsi_mode = rows[i].mode;
			full_pwr = rows[i].full;
			repeat (2) @(negedge clk);
			check("flash_pwr", 8'(flash_pwr), 8'(rows[i].pwr));
			check("read_ok", {7'h00, read_ok}, {7'h00, rows[i].rd_ok});
			repeat (T_WAKE_CYC) @(negedge clk);
		end
		$display("test power table done");
		final_report();
	end

endmodule : fps_seq_test
